// ### design/sarp_consts.svh
// Timing counts, widths and reset values for the scanning converter result port
`ifndef SARP_CONSTS_SVH
`define SARP_CONSTS_SVH

`define SARP_CH_CYC 7'h50
`define SARP_LAST_PH 7'h4F
`define SARP_CONV_PH 7'h08
`define SARP_TRIAL_SPAN 7'h40
`define SARP_WR_DUE_PH 7'h48
`define SARP_STAT_SHORT 7'h08
`define SARP_STAT_LONG 7'h48
`define SARP_STARTUP_CYC 10'h320
`define SARP_CH0_THRESH 7'h28
`define SARP_FIRST_CH 3'h0
`define SARP_LAST_CH 3'h0
`define SARP_RESULT_RST 8'h00
`define SARP_TRIAL_MSB 8'h80
`define SARP_BUS_IDLE 8'hFF

`endif

// ### design/sarp_device.sv
// Device end: successive-approximation scan, result memory and read port
`timescale 1ns/1ps
`include "sarp_consts.svh"

// Contract
// - Result writes only while processor not addressing
// - Address 000..111 selects channel 0..7
// - Latch transparent while strobe high, holds after
// - Host ties strobe high or pulses it
// - Select high: data outputs not driven
// - Select low: drive addressed result, anytime
// - Trial bits MSB first, cleared if DAC greater
// - After LSB decision register holds result
// - Memory write six clocks before status falls
// - Status low 8 clocks, channel 0 72
// - Host measures status width to find channel 0
// - Conversion clock kept at most 1200 kHz
// - 80 clocks per channel, continuous scan
// - Channel decrements at status fall, convert 8 later
// - Start-up sequence at most 800 clocks
module sarp_device (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Processor pins
  sarp_if.device bus,
  // Analog front end
  input wire logic comp_dac_gt,
  output sarp_pkg::sarp_data_t dac_code,
  output sarp_pkg::sarp_ch_t mux_ch,
  output logic scanning
);
  import sarp_pkg::*;

  sarp_dev_state_t state;
  sarp_dev_state_t next_state;
  logic [9:0] boot_cnt;
  logic [9:0] next_boot_cnt;
  logic [6:0] phase;
  logic [6:0] next_phase;
  sarp_ch_t chan;
  sarp_ch_t next_chan;
  sarp_data_t sar;
  sarp_data_t next_sar;
  logic [6:0] stat_cnt;
  logic [6:0] next_stat_cnt;
  logic stat_n;
  logic next_stat_n;
  logic pend;
  logic next_pend;
  sarp_ch_t pend_ch;
  sarp_ch_t next_pend_ch;
  sarp_data_t pend_data;
  sarp_data_t next_pend_data;
  logic scan_on;
  logic next_scan_on;
  logic [6:0] rel;
  logic [2:0] bit_i;
  logic trial;
  logic wr_fire;

  sarp_data_t mem [8];
  sarp_ch_t addr_lat;
  sarp_ch_t next_addr_lat;
  sarp_ch_t rd_sel;
  sarp_data_t rd_word;
  sarp_data_t next_data_o;
  logic next_data_oe;

  // Scan sequencer, approximation register and status pulse
  always_comb begin
    next_state = state;
    next_boot_cnt = boot_cnt;
    next_phase = phase;
    next_chan = chan;
    next_sar = sar;
    next_stat_cnt = stat_cnt;
    next_stat_n = stat_n;
    next_pend = pend;
    next_pend_ch = pend_ch;
    next_pend_data = pend_data;
    next_scan_on = scan_on;
    rel = phase - `SARP_CONV_PH;
    bit_i = 3'h7 - rel[5:3];
    trial = (phase >= `SARP_CONV_PH) && (rel < `SARP_TRIAL_SPAN);
    // Processor addressing the memory blocks the update
    wr_fire = pend && bus.cs_n;
    if (wr_fire) begin
      next_pend = 1'b0;
    end
    case (state)
      SARP_BOOT: begin
        next_boot_cnt = boot_cnt + 10'h001;
        if (boot_cnt == `SARP_STARTUP_CYC - 10'h001) begin
          next_state = SARP_SCAN;
          next_phase = `SARP_CONV_PH;
          next_chan = `SARP_FIRST_CH;
          next_scan_on = 1'b1;
        end
      end
      SARP_SCAN: begin
        next_phase = (phase == `SARP_LAST_PH) ? 7'h00 : phase + 7'h01;
        if (phase == `SARP_CONV_PH) begin
          next_sar = `SARP_TRIAL_MSB;
        end else if (trial && rel[2:0] == 3'h0) begin
          next_sar[bit_i] = 1'b1;
        end
        if (trial && rel[2:0] == 3'h7 && comp_dac_gt) begin
          next_sar[bit_i] = 1'b0;
        end
        // A newer result replaces one still held off by a long read
        if (phase == `SARP_WR_DUE_PH) begin
          next_pend = 1'b1;
          next_pend_ch = chan;
          next_pend_data = sar;
        end
        if (phase == `SARP_LAST_PH) begin
          next_stat_n = 1'b0;
          next_chan = chan - 3'h1;
          next_stat_cnt = (chan == `SARP_LAST_CH) ? `SARP_STAT_LONG
                                                  : `SARP_STAT_SHORT;
        end else if (!stat_n) begin
          next_stat_cnt = stat_cnt - 7'h01;
          if (stat_cnt == 7'h01) begin
            next_stat_n = 1'b1;
          end
        end
      end
      default: begin
        next_state = SARP_BOOT;
        next_boot_cnt = 10'h000;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= SARP_BOOT;
      boot_cnt <= 10'h000;
      phase <= 7'h00;
      chan <= `SARP_FIRST_CH;
      sar <= `SARP_RESULT_RST;
      stat_cnt <= 7'h00;
      stat_n <= 1'b1;
      pend <= 1'b0;
      pend_ch <= `SARP_FIRST_CH;
      pend_data <= `SARP_RESULT_RST;
      scan_on <= 1'b0;
    end else begin
      state <= next_state;
      boot_cnt <= next_boot_cnt;
      phase <= next_phase;
      chan <= next_chan;
      sar <= next_sar;
      stat_cnt <= next_stat_cnt;
      stat_n <= next_stat_n;
      pend <= next_pend;
      pend_ch <= next_pend_ch;
      pend_data <= next_pend_data;
      scan_on <= next_scan_on;
    end
  end

  // Result memory, one entry per channel
  for (genvar i = 0; i < 8; i++) begin : g_mem
    sarp_data_t next_entry;
    always_comb begin
      next_entry = mem[i];
      if (wr_fire && pend_ch == 3'(i)) begin
        next_entry = pend_data;
      end
    end
    always_ff @(posedge mclk) begin
      if (srst) begin
        mem[i] <= `SARP_RESULT_RST;
      end else begin
        mem[i] <= next_entry;
      end
    end
  end

  // Read port: address latch and registered output drivers
  always_comb begin
    next_addr_lat = bus.ale ? bus.addr : addr_lat;
    rd_sel = bus.ale ? bus.addr : addr_lat;
    rd_word = mem[rd_sel];
    next_data_o = `SARP_RESULT_RST;
    next_data_oe = 1'b0;
    if (!bus.cs_n) begin
      next_data_o = rd_word;
      next_data_oe = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      addr_lat <= 3'h0;
      bus.data_o <= `SARP_RESULT_RST;
      bus.data_oe <= 1'b0;
    end else begin
      addr_lat <= next_addr_lat;
      bus.data_o <= next_data_o;
      bus.data_oe <= next_data_oe;
    end
  end

  assign bus.status_n = stat_n;
  assign dac_code = sar;
  assign mux_ch = chan;
  assign scanning = scan_on;

endmodule : sarp_device

// ### design/sarp_host.sv
// Host end: channel reads over the result port and channel 0 detection
`timescale 1ns/1ps
`include "sarp_consts.svh"
module sarp_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Processor pins
  sarp_if.host bus,
  // User side
  input wire logic sep_bus,
  input wire logic rd_req,
  input wire sarp_pkg::sarp_ch_t rd_ch,
  output logic rd_busy,
  output logic rd_valid,
  output sarp_pkg::sarp_data_t rd_data,
  output logic conv_seen,
  output logic ch0_seen
);
  import sarp_pkg::*;

  sarp_host_state_t state;
  sarp_host_state_t next_state;
  logic ale;
  logic next_ale;
  sarp_ch_t addr;
  sarp_ch_t next_addr;
  logic cs_n;
  logic next_cs_n;
  logic next_rd_busy;
  logic next_rd_valid;
  sarp_data_t next_rd_data;
  logic stat_q;
  logic [6:0] low_cnt;
  logic [6:0] next_low_cnt;
  logic next_conv_seen;
  logic next_ch0_seen;

  // Read sequencer
  always_comb begin
    next_state = state;
    next_ale = ale;
    next_addr = addr;
    next_cs_n = cs_n;
    next_rd_busy = rd_busy;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    case (state)
      SARP_H_IDLE: begin
        next_ale = sep_bus;
        if (rd_req) begin
          next_addr = rd_ch;
          next_ale = 1'b1;
          next_rd_busy = 1'b1;
          next_state = SARP_H_ADDR;
        end
      end
      SARP_H_ADDR: begin
        // Falling strobe captures the address on a shared bus
        next_ale = sep_bus;
        next_state = SARP_H_SEL;
      end
      SARP_H_SEL: begin
        next_cs_n = 1'b0;
        next_state = SARP_H_WAIT;
      end
      SARP_H_WAIT: begin
        next_state = SARP_H_CAP;
      end
      SARP_H_CAP: begin
        next_rd_data = bus.data_bus;
        next_rd_valid = 1'b1;
        next_rd_busy = 1'b0;
        next_cs_n = 1'b1;
        next_state = SARP_H_IDLE;
      end
      default: begin
        next_state = SARP_H_IDLE;
        next_cs_n = 1'b1;
        next_rd_busy = 1'b0;
      end
    endcase
  end

  // Status pulse width measurement; saturates rather than wraps
  always_comb begin
    next_low_cnt = low_cnt;
    next_conv_seen = 1'b0;
    next_ch0_seen = 1'b0;
    if (!bus.status_n) begin
      next_low_cnt = (low_cnt == 7'h7F) ? low_cnt : low_cnt + 7'h01;
    end else begin
      next_low_cnt = 7'h00;
      if (!stat_q) begin
        next_conv_seen = 1'b1;
        next_ch0_seen = (low_cnt >= `SARP_CH0_THRESH);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= SARP_H_IDLE;
      ale <= 1'b1;
      addr <= 3'h0;
      cs_n <= 1'b1;
      rd_busy <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= `SARP_RESULT_RST;
      stat_q <= 1'b1;
      low_cnt <= 7'h00;
      conv_seen <= 1'b0;
      ch0_seen <= 1'b0;
    end else begin
      state <= next_state;
      ale <= next_ale;
      addr <= next_addr;
      cs_n <= next_cs_n;
      rd_busy <= next_rd_busy;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      stat_q <= bus.status_n;
      low_cnt <= next_low_cnt;
      conv_seen <= next_conv_seen;
      ch0_seen <= next_ch0_seen;
    end
  end

  assign bus.ale = ale;
  assign bus.addr = addr;
  assign bus.cs_n = cs_n;

endmodule : sarp_host

// ### design/sarp_if.sv
// Processor-side pins between the converter result port and its host
`timescale 1ns/1ps
`include "sarp_consts.svh"
interface sarp_if;
  import sarp_pkg::*;

  logic ale;
  sarp_ch_t addr;
  logic cs_n;
  sarp_data_t data_o;
  logic data_oe;
  logic status_n;
  sarp_data_t data_bus;

  // Pulled-up bus when the device does not drive
  assign data_bus = data_oe ? data_o : `SARP_BUS_IDLE;

  modport device (
    input ale,
    input addr,
    input cs_n,
    output data_o,
    output data_oe,
    output status_n
  );

  modport host (
    output ale,
    output addr,
    output cs_n,
    input data_bus,
    input status_n
  );

endinterface : sarp_if

// ### design/sarp_pkg.sv
// Types shared by both ends of the scanning converter result port
package sarp_pkg;

  typedef logic [2:0] sarp_ch_t;
  typedef logic [7:0] sarp_data_t;

  typedef enum logic [1:0] {
    SARP_BOOT = 2'b01,
    SARP_SCAN = 2'b10
  } sarp_dev_state_t;

  typedef enum logic [4:0] {
    SARP_H_IDLE = 5'b00001,
    SARP_H_ADDR = 5'b00010,
    SARP_H_SEL = 5'b00100,
    SARP_H_WAIT = 5'b01000,
    SARP_H_CAP = 5'b10000
  } sarp_host_state_t;

endpackage : sarp_pkg

// ### sim/sarp_bench.sv
// Both ends joined, with a comparator model and result checks
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch %0t %s", $time, m); end end
module sarp_bench;
  import sarp_pkg::*;
  logic mclk;
  logic srst;
  logic comp_dac_gt;
  logic sep_bus;
  logic rd_req;
  sarp_ch_t rd_ch;
  sarp_data_t dac_code;
  sarp_ch_t mux_ch;
  logic scanning;
  logic rd_busy;
  logic rd_valid;
  sarp_data_t rd_data;
  logic conv_seen;
  logic ch0_seen;
  int error_cnt = 0;
  int checked = 0;
  int seed = 32'h708e_b0ff;
  int cyc = 0;
  int lw = 0;
  int rises = 0;
  int convs = 0;
  logic last_long = 1'b0;
  sarp_ch_t exp_ch = 3'h0;
  sarp_data_t ain[8];
  sarp_data_t old[8];
  sarp_if bus_if ();
  sarp_device u_sarp_device (.mclk(mclk), .srst(srst), .bus(bus_if),
    .comp_dac_gt(comp_dac_gt), .dac_code(dac_code), .mux_ch(mux_ch), .scanning(scanning));
  sarp_host u_sarp_host (.mclk(mclk), .srst(srst), .bus(bus_if), .sep_bus(sep_bus),
    .rd_req(rd_req), .rd_ch(rd_ch), .rd_busy(rd_busy), .rd_valid(rd_valid),
    .rd_data(rd_data), .conv_seen(conv_seen), .ch0_seen(ch0_seen));
  sarp_checker u_sarp_checker (.mclk(mclk), .srst(srst), .cs_n(bus_if.cs_n),
    .data_oe(bus_if.data_oe), .data_o(bus_if.data_o), .status_n(bus_if.status_n));

  // Cycle-level model; the real conversion clock must stay within its rated limit
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Ideal comparator: integer inputs make the result equal the input
  always @(negedge mclk) begin
    comp_dac_gt <= dac_code > ain[mux_ch];
  end

  always @(posedge mclk) begin
    if (conv_seen === 1'b1) begin
      convs++;
      `CHK(ch0_seen, last_long, "channel 0 flag")
    end
    if (srst) lw = 0;
    else if (bus_if.status_n === 1'b0) begin
      if (lw == 0) begin
        exp_ch = exp_ch - 3'h1;
        `CHK(mux_ch, exp_ch, "channel step")
      end
      lw++;
    end
    else if (lw > 0) begin
      `CHK(lw, (rises % 8 == 0) ? 72 : 8, "status width")
      last_long = lw >= 40;
      rises++;
      lw = 0;
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic rd(input int ch, output sarp_data_t d);
    int n;
    n = 0;
    @(negedge mclk);
    rd_req = 1'b1;
    rd_ch = ch[2:0];
    @(negedge mclk);
    rd_req = 1'b0;
    `CHK(rd_busy, 1'b1, "read busy")
    while (rd_valid !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    `CHK(rd_valid, 1'b1, "read answer")
    `CHK(rd_busy, 1'b0, "read done")
    d = rd_data;
  endtask : rd

  task automatic check_all();
    sarp_data_t d;
    for (int i = 0; i < 8; i++) begin
      rd(i, d);
      `CHK(d, ain[i], "stored result")
    end
  endtask : check_all

  initial begin
    int n;
    int c;
    int boot_at;
    sarp_data_t d;
    srst = 1'b1;
    sep_bus = 1'b1;
    rd_req = 1'b0;
    rd_ch = 3'h0;
    comp_dac_gt = 1'b0;
    for (int i = 0; i < 8; i++) ain[i] = 8'h00;
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    boot_at = cyc;
    check_all();
    for (int i = 0; i < 8; i++) ain[i] = 8'($random(seed));
    ain[0] = 8'hff;
    n = 0;
    while (scanning !== 1'b1 && n < 800) begin
      @(negedge mclk);
      n++;
    end
    `CHK(scanning, 1'b1, "start-up")
    `CHK((cyc - boot_at) <= 800, 1'b1, "start-up time")
    repeat (720) @(negedge mclk);
    check_all();
    sep_bus = 1'b0;
    check_all();
    // New inputs only in the idle gap, so no conversion sees two values
    while (bus_if.status_n !== 1'b1) @(negedge mclk);
    while (bus_if.status_n !== 1'b0) @(negedge mclk);
    // Reads hammered across a whole scan while results change
    for (int i = 0; i < 8; i++) begin
      old[i] = ain[i];
      ain[i] = 8'($random(seed));
    end
    for (int k = 0; k < 150; k++) begin
      c = $random(seed) & 7;
      sep_bus = 1'($random(seed));
      rd(c, d);
      if (d === old[c]) d = ain[c];
      `CHK(d, ain[c], "result during update")
    end
    repeat (720) @(negedge mclk);
    check_all();
    n = 0;
    while (bus_if.status_n !== 1'b0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    `CHK(convs, rises, "status events")
    summarize();
  end
endmodule : sarp_bench

// ### sim/sarp_checker.sv
// Assertions on the pins between the two ends of the result port
`timescale 1ns/1ps
module sarp_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Watched pins
  input wire logic cs_n,
  input wire logic data_oe,
  input wire sarp_pkg::sarp_data_t data_o,
  input wire logic status_n
);
  import sarp_pkg::*;
  logic [6:0] low_cnt;
  logic [6:0] next_low_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Low samples seen so far in the current status pulse
  always_comb begin
    next_low_cnt = status_n ? 7'h00 : low_cnt + 7'h01;
  end
  always_ff @(posedge mclk) begin
    low_cnt <= srst ? 7'h00 : next_low_cnt;
  end
  a_float_idle: assert property (cs_n |=> !data_oe)
    else $error("data driven without select");
  a_idle_zero: assert property (!data_oe |-> data_o == 8'h00)
    else $error("data not cleared while idle");
  a_drive_sel: assert property (!cs_n |=> data_oe)
    else $error("select not answered");
  a_pulse_min: assert property ($fell(status_n) |-> !status_n [*8])
    else $error("status pulse too short");
  a_pulse_width: assert property ($rose(status_n) |-> low_cnt == 7'h08 || low_cnt == 7'h48)
    else $error("status pulse width wrong");
  a_pulse_cap: assert property (!status_n |-> low_cnt < 7'h48)
    else $error("status pulse too long");
  a_chan_period: assert property ($fell(status_n) |-> ##80 $fell(status_n))
    else $error("channel period wrong");
  // Held-off update keeps the byte under read steady
  a_read_stable: assert property (!cs_n && !$past(cs_n) |=> $stable(data_o))
    else $error("read data changed during select");
  a_long_short: assert property ($rose(status_n) && low_cnt == 7'h48 |->
    ##16 ($rose(status_n) && low_cnt == 7'h08))
    else $error("no short pulse after long one");
endmodule : sarp_checker
